// *** hdl/fsc_pkg.sv ***
package fsc_pkg;
   localparam int unsigned CLK_PERIOD_NS = 20;

   // command opcodes
   localparam logic [7:0] OP_LATCH_SET   = 8'h06;
   localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
   localparam logic [7:0] OP_IDENT_READ  = 8'h9f;
   localparam logic [7:0] OP_MAKER_READ  = 8'h90;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_STATUS_WR   = 8'h01;
   localparam logic [7:0] OP_PAGE_WR     = 8'h02;
   localparam logic [7:0] OP_QUAD_PAGE   = 8'h38;
   localparam logic [7:0] OP_SMALL_WIPE  = 8'h20;
   localparam logic [7:0] OP_LARGE_WIPE  = 8'hd8;
   localparam logic [7:0] OP_FULL_WIPE_A = 8'h60;
   localparam logic [7:0] OP_FULL_WIPE_B = 8'hc7;

   // status byte layout and reset values
   localparam int unsigned ST_BUSY    = 0;
   localparam int unsigned ST_LATCH   = 1;
   localparam int unsigned ST_PROT_LO = 2;
   localparam int unsigned ST_PROT_HI = 5;
   localparam int unsigned ST_QUAD    = 6;
   localparam int unsigned ST_LOCK    = 7;
   localparam logic        QUAD_ON    = 1'b1;
   localparam logic [3:0]  PROT_RESET = 4'h0;
   localparam logic        LOCK_RESET = 1'b0;

   // frame byte counts
   localparam logic [2:0] BIT_LAST    = 3'h7;
   localparam logic [2:0] CNT_MAX     = 3'h7;
   localparam logic [2:0] CMD_BYTES   = 3'h1;
   localparam logic [2:0] WR_BYTES    = 3'h2;
   localparam logic [2:0] ADDR_BYTES  = 3'h4;
   localparam logic [2:0] ADDR_IDX    = 3'h3;
   localparam logic [1:0] IDENT_BYTES = 2'h3;

   // least time in whole clock cycles, never under one
   function automatic int unsigned fsc_cycles(input int unsigned ns);
      int unsigned c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c == 0) ? 1 : c;
   endfunction : fsc_cycles
endpackage : fsc_pkg

// *** hdl/fsc_tmr_if.sv ***
interface fsc_tmr_if;
   logic        start;
   logic [31:0] len;
   logic        busy;
   logic        done;
   modport ctl (output start, output len, input busy, input done);
   modport tmr (input start, input len, output busy, output done);
endinterface : fsc_tmr_if

// *** hdl/fsc_cycle_timer.sv ***
module fsc_cycle_timer (
   // clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_sys_rst,
   // start and busy
   fsc_tmr_if.tmr    tmr
);
   import fsc_pkg::*;

   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic        busy;
   logic        next_busy;

   always_comb begin
      next_cnt  = cnt;
      next_busy = busy;
      if (tmr.start && !busy) begin
         next_cnt  = tmr.len;
         next_busy = 1'b1;
      end else if (busy) begin
         next_cnt  = cnt - 32'h1;
         next_busy = (cnt != 32'h1);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         cnt  <= 32'h0;
         busy <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         busy <= next_busy;
      end
   end

   assign tmr.busy = busy;
   // done marks the last busy cycle
   assign tmr.done = busy && (cnt == 32'h1);

   a_busy_len: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (tmr.start && !busy) |=> busy && cnt == $past(tmr.len))
      else $error("timed cycle length not loaded");

   a_busy_end: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (busy && cnt == 32'h1) |=> !busy)
      else $error("timed cycle overran its length");
endmodule : fsc_cycle_timer

// *** hdl/fsc_flash_status_ctrl.sv ***
// Operation
// - latch-set command sets write latch
// - latch-clear command clears write latch
// - latch cleared at reset, write completions
// - ident sends maker then two device bytes
// - ident ignored while program/erase runs
// - status read always accepted, repeats byte
// - status byte bit layout fixed
// - busy flag high during timed cycles
// - clear latch refuses program/erase/status write
// - protected target: ignore, clear latch
// - full wipe only with protect zero
// - protect bits changed only by status write
// - quad flag always reads one
// - status lock bit defaults zero
// - status write keeps latch, sets busy
// - misaligned chip select rise rejects write
// - timed cycle from rise, clears latch
// - unlocked latch permits protect changes
// - address byte picks maker or device first
module fsc_flash_status_ctrl #(
   parameter int unsigned STATUS_WRITE_TIME_NS = 10_000_000,
   parameter int unsigned PAGE_WRITE_TIME_NS   = 1_000_000,
   parameter int unsigned WIPE_TIME_NS         = 100_000_000,
   parameter logic [7:0]  MAKER_CODE           = 8'h5a, // arbitrary
   parameter logic [7:0]  DEVICE_CODE_HI       = 8'h11, // arbitrary
   parameter logic [7:0]  DEVICE_CODE_LO       = 8'h22  // arbitrary
) (
   // system clock and reset
   input  wire logic       i_clk_sys,
   input  wire logic       i_sys_rst,
   // serial link
   input  wire logic       i_sclk,
   input  wire logic       i_cs_n,
   input  wire logic       i_si,
   output wire logic       o_so,
   output wire logic       o_so_oe,
   // array side
   input  wire logic       i_prot_hit,
   output wire logic [7:0] o_status
);
   import fsc_pkg::*;

   localparam int unsigned STATUS_WRITE_CYC = fsc_cycles(STATUS_WRITE_TIME_NS);
   localparam int unsigned PAGE_WRITE_CYC   = fsc_cycles(PAGE_WRITE_TIME_NS);
   localparam int unsigned WIPE_CYC         = fsc_cycles(WIPE_TIME_NS);

   if (STATUS_WRITE_TIME_NS == 0 || PAGE_WRITE_TIME_NS == 0 || WIPE_TIME_NS == 0) begin : g_chk
      $error("timed cycle lengths must be nonzero");
   end

   function automatic logic [7:0] id_byte(input logic [1:0] sel);
      case (sel)
         2'h0:    return MAKER_CODE;
         2'h1:    return DEVICE_CODE_HI;
         default: return DEVICE_CODE_LO;
      endcase
   endfunction : id_byte

   fsc_tmr_if tmr_if ();

   fsc_cycle_timer u_timer (
      .i_clk_sys (i_clk_sys),
      .i_sys_rst (i_sys_rst),
      .tmr       (tmr_if)
   );

   // ---------------- link domain, serial clock ----------------
   logic       fresh;
   logic       frame_tog;
   logic       next_frame_tog;
   logic [2:0] bit_idx;
   logic [2:0] next_bit_idx;
   logic [2:0] byte_cnt;
   logic [2:0] next_byte_cnt;
   logic [7:0] shreg;
   logic [7:0] next_shreg;
   logic [7:0] opcode;
   logic [7:0] next_opcode;
   logic [7:0] wr_data;
   logic [7:0] next_wr_data;
   logic [7:0] addr_lo;
   logic [7:0] next_addr_lo;
   logic [7:0] status_m;
   logic [7:0] status_l;

   // marks the first rising edge of each frame
   always_ff @(posedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) begin
         fresh <= 1'b1;
      end else begin
         fresh <= 1'b0;
      end
   end

   always_comb begin
      logic [2:0] b;
      logic [2:0] n;
      logic [7:0] sh;
      b              = fresh ? 3'h0 : bit_idx;
      n              = fresh ? 3'h0 : byte_cnt;
      sh             = {shreg[6:0], i_si};
      next_shreg     = sh;
      next_bit_idx   = b + 3'h1;
      next_byte_cnt  = n;
      next_opcode    = opcode;
      next_wr_data   = wr_data;
      next_addr_lo   = addr_lo;
      next_frame_tog = fresh ? ~frame_tog : frame_tog;
      if (b == BIT_LAST) begin
         if (n != CNT_MAX) begin
            next_byte_cnt = n + 3'h1;
         end
         if (n == 3'h0) begin
            next_opcode = sh;
         end
         if (n == CMD_BYTES) begin
            next_wr_data = sh;
         end
         if (n == ADDR_IDX) begin
            next_addr_lo = sh;
         end
      end
   end

   // toggle must start known or no frame ever commits; sclk stands still
   // during reset, so the release meets no link edge
   always_ff @(posedge i_sclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         frame_tog <= 1'b0;
      end else begin
         frame_tog <= next_frame_tog;
      end
   end

   // frame fields stay put after chip select rises, so the system side
   // may read them once the rise has been synchronised
   always_ff @(posedge i_sclk) begin
      bit_idx   <= next_bit_idx;
      byte_cnt  <= next_byte_cnt;
      shreg     <= next_shreg;
      opcode    <= next_opcode;
      wr_data   <= next_wr_data;
      addr_lo   <= next_addr_lo;
      status_m  <= o_status;
      status_l  <= status_m;
   end

   // output side, falling edge
   logic [7:0] out_sh;
   logic [7:0] next_out_sh;
   logic       out_en;
   logic       next_out_en;
   logic [1:0] id_sel;
   logic [1:0] next_id_sel;

   always_comb begin
      next_out_sh = {out_sh[6:0], 1'b0};
      next_out_en = out_en;
      next_id_sel = id_sel;
      if (!fresh && bit_idx == 3'h0 && byte_cnt != 3'h0) begin
         next_out_en = 1'b0;
         next_out_sh = 8'h00;
         unique case (opcode)
            OP_STATUS_READ: begin
               next_out_sh = status_l;
               next_out_en = 1'b1;
            end
            OP_IDENT_READ: begin
               if (byte_cnt == CMD_BYTES) begin
                  next_id_sel = 2'h0;
               end else begin
                  next_id_sel = id_sel + 2'h1;
               end
               // busy array: command not decoded
               if (!status_l[ST_BUSY] && (byte_cnt == CMD_BYTES ||
                   id_sel != IDENT_BYTES - 2'h1)) begin
                  next_out_sh = id_byte(next_id_sel);
                  next_out_en = 1'b1;
               end
            end
            OP_MAKER_READ: begin
               if (byte_cnt >= ADDR_BYTES) begin
                  next_id_sel = (byte_cnt == ADDR_BYTES) ? {1'b0, addr_lo[0]}
                                                         : {1'b0, ~id_sel[0]};
                  next_out_sh = id_byte(next_id_sel);
                  next_out_en = 1'b1;
               end
            end
            default: begin
               next_out_en = 1'b0;
            end
         endcase
      end
   end

   always_ff @(negedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) begin
         out_sh <= 8'h00;
         out_en <= 1'b0;
         id_sel <= 2'h0;
      end else begin
         out_sh <= next_out_sh;
         out_en <= next_out_en;
         id_sel <= next_id_sel;
      end
   end

   assign o_so    = out_sh[7];
   assign o_so_oe = out_en && !i_cs_n;

   // ---------------- system domain ----------------
   logic       cs_m;
   logic       cs_s;
   logic       cs_d;
   logic       tog_m;
   logic       tog_s;
   logic       tog_seen;
   logic       next_tog_seen;
   logic       latch;
   logic       next_latch;
   logic [3:0] prot;
   logic [3:0] next_prot;
   logic       lock;
   logic       next_lock;
   logic       commit;
   logic       aligned;
   logic       busy;
   logic       pe_op;
   logic       full_op;

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         cs_m  <= 1'b1;
         cs_s  <= 1'b1;
         cs_d  <= 1'b1;
         tog_m <= 1'b0;
         tog_s <= 1'b0;
      end else begin
         cs_m  <= i_cs_n;
         cs_s  <= cs_m;
         cs_d  <= cs_s;
         tog_m <= frame_tog;
         tog_s <= tog_m;
      end
   end

   assign busy    = tmr_if.busy;
   // a rise without a clocked frame is not a command
   assign commit  = cs_s && !cs_d && (tog_s != tog_seen);
   assign aligned = (bit_idx == 3'h0);
   assign full_op = (opcode == OP_FULL_WIPE_A) || (opcode == OP_FULL_WIPE_B);
   assign pe_op   = (opcode == OP_PAGE_WR) || (opcode == OP_QUAD_PAGE) ||
                    (opcode == OP_SMALL_WIPE) || (opcode == OP_LARGE_WIPE);

   always_comb begin
      next_tog_seen = commit ? tog_s : tog_seen;
      next_latch    = latch;
      next_prot     = prot;
      next_lock     = lock;
      tmr_if.start  = 1'b0;
      tmr_if.len    = 32'h0;
      if (tmr_if.done) begin
         next_latch = 1'b0;
      end
      // timed cycle running: only status read and maker read are served, on the link side
      if (commit && !busy && aligned) begin
         if (opcode == OP_LATCH_SET && byte_cnt == CMD_BYTES) begin
            next_latch = 1'b1;
         end else if (opcode == OP_LATCH_CLEAR && byte_cnt == CMD_BYTES) begin
            next_latch = 1'b0;
         end else if (latch) begin
            if (opcode == OP_STATUS_WR && byte_cnt >= WR_BYTES) begin
               // lock not checked: writable; latch untouched here, timer start sets busy
               next_prot    = wr_data[ST_PROT_HI:ST_PROT_LO];
               next_lock    = wr_data[ST_LOCK];
               tmr_if.start = 1'b1;
               tmr_if.len   = STATUS_WRITE_CYC;
            end else if (pe_op && byte_cnt >= ADDR_BYTES) begin
               if (i_prot_hit) begin
                  next_latch = 1'b0;
               end else begin
                  tmr_if.start = 1'b1;
                  tmr_if.len   = (opcode == OP_SMALL_WIPE || opcode == OP_LARGE_WIPE)
                                 ? WIPE_CYC : PAGE_WRITE_CYC;
               end
            end else if (full_op && byte_cnt == CMD_BYTES) begin
               if (prot != PROT_RESET) begin
                  next_latch = 1'b0;
               end else begin
                  tmr_if.start = 1'b1;
                  tmr_if.len   = WIPE_CYC;
               end
            end
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         tog_seen <= 1'b0;
         latch    <= 1'b0;
         prot     <= PROT_RESET;
         lock     <= LOCK_RESET;
      end else begin
         tog_seen <= next_tog_seen;
         latch    <= next_latch;
         prot     <= next_prot;
         lock     <= next_lock;
      end
   end

   assign o_status = {lock, QUAD_ON, prot, latch, busy};

   a_latch_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (commit && !busy && aligned && opcode == OP_LATCH_SET && byte_cnt == CMD_BYTES)
      |=> o_status[ST_LATCH])
      else $error("latch not set by latch-set command");

   a_latch_clear: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (commit && !busy && aligned && opcode == OP_LATCH_CLEAR && byte_cnt == CMD_BYTES)
      |=> !o_status[ST_LATCH])
      else $error("latch not cleared by latch-clear command");

   a_done_clears: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      $fell(busy) |-> !latch && $past(tmr_if.done) && !o_status[ST_LATCH])
      else $error("latch still set after timed cycle");

   a_refuse_nolatch: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (commit && !latch && !busy) |=> !busy)
      else $error("timed cycle started with latch clear");

   a_prot_ignore: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (commit && !busy && aligned && latch && pe_op && byte_cnt >= ADDR_BYTES && i_prot_hit)
      |=> !busy && !latch)
      else $error("protected target not ignored");

   a_full_guard: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (tmr_if.start && full_op && !pe_op && commit) |-> prot == PROT_RESET)
      else $error("full wipe started with protect set");

   a_wr_fields: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (commit && !busy && aligned && latch && opcode == OP_STATUS_WR && byte_cnt >= WR_BYTES)
      |=> busy && latch && prot == $past(wr_data[ST_PROT_HI:ST_PROT_LO])
          && lock == $past(wr_data[ST_LOCK]))
      else $error("status write fields wrong");

   a_misalign_rej: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (commit && !aligned) |=> $stable(prot) && $stable(lock) && !$rose(busy))
      else $error("misaligned frame executed");

   a_quad_one: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      o_status[ST_QUAD] && (o_status[ST_BUSY] == tmr_if.busy))
      else $error("quad flag or busy bit wrong");
endmodule : fsc_flash_status_ctrl

// *** testbench/fsc_host_model.sv ***
module fsc_host_model (
   // serial link toward the device
   output logic      o_sclk,
   output logic      o_cs_n,
   output logic      o_si,
   // device answer
   input  wire logic i_so,
   input  wire logic i_so_oe
);
   timeunit 1ns;
   timeprecision 1ns;

   localparam time HALF = 40;
   logic oe_seen;

   initial begin
      o_sclk  = 1'b0;
      o_si    = 1'b1;
      oe_seen = 1'b0;
      // a late rise so the cs-cleared link flops surely see their clear
      #1 o_cs_n = 1'b1;
   end

   // clock stands low outside frames; one opcode or byte per frame field
   task automatic frame(input int nbits, input logic [63:0] tx, output logic [63:0] rx);
      rx      = '0;
      oe_seen = 1'b0;
      #13;
      o_cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         o_si = tx[63 - i];
         #HALF o_sclk = 1'b1;
         rx      = {rx[62:0], i_so};
         oe_seen = oe_seen | i_so_oe;
         #HALF o_sclk = 1'b0;
      end
      #HALF o_cs_n = 1'b1;
      // released line must not keep showing the last bit
      o_si = ~o_si;
      // gap well over the commit window
      #200;
   endtask : frame
endmodule : fsc_host_model

// *** testbench/test_flash_status_write_enable_ctrl.sv ***
module test_flash_status_write_enable_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   import fsc_pkg::*;

   localparam int         SW_NS  = 4000;
   localparam int         PG_NS  = 20000;
   localparam int         WP_NS  = 200;
   localparam logic [7:0] MAKER  = 8'h5a; // arbitrary
   localparam logic [7:0] DEV_HI = 8'h11; // arbitrary
   localparam logic [7:0] DEV_LO = 8'h22; // arbitrary

   logic        i_clk_sys = 1'b0;
   logic        i_sys_rst = 1'b0;
   logic        i_prot_hit = 1'b0;
   wire         sclk;
   wire         cs_n;
   wire         si;
   wire         so;
   wire         so_oe;
   wire [7:0]   status;
   logic [63:0] rx;
   int          miscompares = 0;
   int          checks = 0;
   int          busy_cnt = 0;
   int          busy_len = 0;

   always #10 i_clk_sys = ~i_clk_sys;

   fsc_flash_status_ctrl #(
      .STATUS_WRITE_TIME_NS (SW_NS),
      .PAGE_WRITE_TIME_NS   (PG_NS),
      .WIPE_TIME_NS         (WP_NS),
      .MAKER_CODE           (MAKER),
      .DEVICE_CODE_HI       (DEV_HI),
      .DEVICE_CODE_LO       (DEV_LO)
   ) uut (
      .i_clk_sys  (i_clk_sys),
      .i_sys_rst  (i_sys_rst),
      .i_sclk     (sclk),
      .i_cs_n     (cs_n),
      .i_si       (si),
      .o_so       (so),
      .o_so_oe    (so_oe),
      .i_prot_hit (i_prot_hit),
      .o_status   (status)
   );

   fsc_host_model host (
      .o_sclk  (sclk),
      .o_cs_n  (cs_n),
      .o_si    (si),
      .i_so    (so),
      .i_so_oe (so_oe)
   );

   // length of the last busy stretch in system cycles
   always @(posedge i_clk_sys) begin
      if (status[0] === 1'b1) begin
         busy_cnt <= busy_cnt + 1;
      end else if (busy_cnt != 0) begin
         busy_len <= busy_cnt;
         busy_cnt <= 0;
      end
   end

   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check8

   task automatic check32(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check32

   task automatic summarize();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize

   task automatic xfer(input int n, input logic [63:0] tx);
      @(negedge i_clk_sys);
      host.frame(n, tx, rx);
   endtask : xfer

   task automatic wait_idle();
      int k;
      k = 0;
      while (status[0] !== 1'b0 && k < 3000) begin
         @(negedge i_clk_sys);
         k++;
      end
      repeat (3) @(negedge i_clk_sys);
   endtask : wait_idle

   task automatic t_reset();
      check8(status, 8'h40);
      xfer(16, {OP_STATUS_READ, 56'h0});
      check8(rx[7:0], 8'h40);
      $display("test reset done");
   endtask : t_reset

   task automatic t_latch();
      xfer(8, {OP_LATCH_SET, 56'h0});
      check8(status, 8'h42);
      xfer(8, {OP_LATCH_CLEAR, 56'h0});
      check8(status, 8'h40);
      xfer(16, {OP_STATUS_WR, 8'h3c, 48'h0});
      check8(status, 8'h40);
      xfer(8, {OP_LATCH_SET, 56'h0});
      xfer(12, {OP_STATUS_WR, 8'h3c, 48'h0});
      check8(status, 8'h42);
      xfer(8, {OP_LATCH_CLEAR, 56'h0});
      $display("test latch done");
   endtask : t_latch

   task automatic t_ident();
      xfer(32, {OP_IDENT_READ, 56'h0});
      check32({8'h0, rx[23:0]}, {8'h0, MAKER, DEV_HI, DEV_LO});
      check8({7'h0, host.oe_seen}, 8'h1);
      xfer(48, {OP_MAKER_READ, 24'h0, 32'h0});
      check32({16'h0, rx[15:0]}, {16'h0, MAKER, DEV_HI});
      xfer(48, {OP_MAKER_READ, 24'h1, 32'h0});
      check32({16'h0, rx[15:0]}, {16'h0, DEV_HI, MAKER});
      $display("test ident done");
   endtask : t_ident

   task automatic t_program();
      xfer(8, {OP_LATCH_SET, 56'h0});
      xfer(32, {OP_PAGE_WR, 24'h0, 32'h0});
      check8(status, 8'h43);
      xfer(24, {OP_STATUS_READ, 56'h0});
      check32({16'h0, rx[15:0]}, 32'h4343);
      xfer(32, {OP_IDENT_READ, 56'h0});
      check8({7'h0, host.oe_seen}, 8'h0);
      wait_idle();
      check8(status, 8'h40);
      check32(busy_len, PG_NS / 20);
      $display("test program done");
   endtask : t_program

   task automatic t_status_write();
      xfer(8, {OP_LATCH_SET, 56'h0});
      xfer(16, {OP_STATUS_WR, 8'h3f, 48'h0});
      check8(status, 8'h7f);
      wait_idle();
      check8(status, 8'h7c);
      check32(busy_len, SW_NS / 20);
      xfer(8, {OP_LATCH_SET, 56'h0});
      xfer(16, {OP_STATUS_WR, 8'hbc, 48'h0});
      wait_idle();
      check8(status, 8'hfc);
      $display("test status write done");
   endtask : t_status_write

   task automatic t_protect();
      logic [7:0] ops [4];
      ops = '{OP_PAGE_WR, OP_QUAD_PAGE, OP_SMALL_WIPE, OP_LARGE_WIPE};
      i_prot_hit = 1'b1;
      foreach (ops[i]) begin
         xfer(8, {OP_LATCH_SET, 56'h0});
         xfer(32, {ops[i], 24'h0, 32'h0});
         check8(status, 8'hfc);
      end
      i_prot_hit = 1'b0;
      xfer(8, {OP_LATCH_SET, 56'h0});
      xfer(8, {OP_FULL_WIPE_A, 56'h0});
      check8(status, 8'hfc);
      xfer(8, {OP_LATCH_SET, 56'h0});
      xfer(8, {OP_FULL_WIPE_B, 56'h0});
      check8(status, 8'hfc);
      // protect cleared: the full wipe must now run
      xfer(8, {OP_LATCH_SET, 56'h0});
      xfer(16, {OP_STATUS_WR, 8'h00, 48'h0});
      wait_idle();
      check8(status, 8'h40);
      xfer(8, {OP_LATCH_SET, 56'h0});
      xfer(8, {OP_FULL_WIPE_B, 56'h0});
      check8(status, 8'h43);
      wait_idle();
      check8(status, 8'h40);
      check32(busy_len, WP_NS / 20);
      $display("test protect done");
   endtask : t_protect

   initial begin
      // a real rising edge, so the link toggle's clear is seen
      #1 i_sys_rst = 1'b1;
      repeat (4) @(negedge i_clk_sys);
      i_sys_rst = 1'b0;
      repeat (3) @(negedge i_clk_sys);
      t_reset();
      t_latch();
      t_ident();
      t_program();
      t_status_write();
      t_protect();
      summarize();
   end

   // all tests finish well inside this span (about 50,000 cycles)
   initial begin
      #1_000_000;
      miscompares++;
      summarize();
   end
endmodule : test_flash_status_write_enable_ctrl
